// ===== hw/idps_params.svh
// offsets, field positions, reset values and timing for the injector sequencer
`ifndef IDPS_PARAMS_SVH
`define IDPS_PARAMS_SVH
`define IDPS_CLK_NS 4
`define IDPS_TICK_NS 1000
`define IDPS_MAX_CMD_MS 5
`define IDPS_MAX_CMD_TICKS (`IDPS_MAX_CMD_MS * 1000000 / `IDPS_TICK_NS)
`define IDPS_NCH 3
`define IDPS_NPH 8
`define IDPS_OFS_CTRL 8'h00
`define IDPS_OFS_STATUS 8'h04
`define IDPS_OFS_BOOST 8'h08
`define IDPS_OFS_RECOV 8'h0C
`define IDPS_OFS_SPLEN 8'h10
`define IDPS_OFS_CALLEN 8'h14
`define IDPS_OFS_CALPER 8'h18
`define IDPS_OFS_CALCNT 8'h1C
`define IDPS_OFS_TRNLEN 8'h20
`define IDPS_OFS_TRNGAP 8'h24
`define IDPS_OFS_TRNCNT 8'h28
`define IDPS_OFS_ANGREF 8'h2C
`define IDPS_OFS_ANGSTART 8'h30
`define IDPS_OFS_ANGSTEP 8'h34
`define IDPS_OFS_PHASE 8'h40
`define IDPS_B_ALLOW 0
`define IDPS_B_BOOST 1
`define IDPS_B_DRIVE 2
`define IDPS_B_CHON 3
`define IDPS_B_INV 6
`define IDPS_B_SRC 9
`define IDPS_B_CAP 11
`define IDPS_B_EARLY 12
`define IDPS_B_TRGFALL 13
`define IDPS_B_SPREQ 14
`define IDPS_B_SPTGT 15
`define IDPS_B_FLOOR 8
`define IDPS_B_PLEN 16
`define IDPS_B_HV 31
`define IDPS_RST_BOOST 8'h4B
`endif

// ===== hw/idps_pkg.sv
// types shared by the injector drive phase sequencer
package idps_pkg;
  typedef enum logic [1:0] {
    IDPS_SRC_DIRECT, IDPS_SRC_CAL, IDPS_SRC_TRAIN, IDPS_SRC_ANGLE
  } idps_src_t;
  typedef enum logic [1:0] {IDPS_PG_IDLE, IDPS_PG_PULSE, IDPS_PG_GAP} idps_pg_t;
  typedef enum logic [1:0] {IDPS_SQ_IDLE, IDPS_SQ_DRIVE, IDPS_SQ_DISCH, IDPS_SQ_RECOV} idps_sq_t;
endpackage

// ===== hw/idps_top.sv
// injector drive phase sequencer: command sources, gating and phase table drive
`timescale 1ns/10ps
`include "idps_params.svh"
module idps_top
  import idps_pkg::*;
#(
  parameter int MAX_CMD_TICKS = `IDPS_MAX_CMD_TICKS
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLOT_OCCUPIED,
  input wire logic EXT_POWER_OK,
  input wire logic [2:0] DIRECT_IN,
  input wire logic TRIGGER_IN,
  input wire logic [15:0] CRANK_ANGLE,
  input wire logic [7:0] SENSE_CURRENT,
  output logic MODULE_DETECTED,
  output logic BOOST_EN,
  output logic [7:0] BOOST_SETPOINT,
  output logic [2:0] CH_SELECT,
  output logic HV_ON,
  output logic LV_ON,
  output logic DISCHARGE_ON,
  output logic RECOVER_ON
);
  localparam int TICK_CYCLES = `IDPS_TICK_NS / `IDPS_CLK_NS;
  localparam int NCH = `IDPS_NCH;
  localparam int NPH = `IDPS_NPH;

  logic allow_r, boost_on_r, drv_en_r, cap_r, early_r, trg_fall_r, sp_req_r;
  logic [2:0] chan_on_r, invert_r;
  idps_src_t src_r;
  logic [1:0] sp_tgt_r;
  logic [7:0] boost_set_r;
  logic [15:0] recov_len_r, sp_len_r, cal_len_r, cal_per_r, cal_rem_r;
  logic [15:0] trn_len_r, trn_gap_r, ang_ref_r, ang_start_r, ang_step_r;
  logic [3:0] trn_cnt_r;
  logic [7:0] ph_ceil_r [NPH];
  logic [7:0] ph_floor_r [NPH];
  logic [14:0] ph_len_r [NPH];
  logic [NPH-1:0] ph_hv_r;

  // external pins: two-stage synchronisers, stage one read by stage two only
  logic [5:0] pin_s1_r, pin_s2_r;
  logic trig_d_r, det_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      trig_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {TRIGGER_IN, EXT_POWER_OK, SLOT_OCCUPIED, DIRECT_IN};
      pin_s2_r <= pin_s1_r;
      trig_d_r <= pin_s2_r[5];
    end
  end
  wire [2:0] din_s = pin_s2_r[2:0];
  wire trig_s = pin_s2_r[5];

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) det_r <= 1'b0;
    else det_r <= allow_r & pin_s2_r[3] & pin_s2_r[4];
  end

  // microsecond timebase for all lengths
  logic [8:0] pre_r;
  logic tick;
  assign tick = (pre_r == 9'(TICK_CYCLES - 1));
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) pre_r <= 9'h000;
    else if (tick) pre_r <= 9'h000;
    else pre_r <= pre_r + 9'h001;
  end

  // apb slave, no wait states
  wire wr = PSEL & PENABLE & PWRITE;
  wire setup = PSEL & ~PENABLE;
  wire ph_hit = (PADDR[7:5] == 3'b010) && (PADDR[1:0] == 2'b00);
  wire [2:0] ph_ix = PADDR[4:2];
  logic mapped;
  always_comb begin
    unique case (PADDR)
      `IDPS_OFS_CTRL, `IDPS_OFS_STATUS, `IDPS_OFS_BOOST, `IDPS_OFS_RECOV,
      `IDPS_OFS_SPLEN, `IDPS_OFS_CALLEN, `IDPS_OFS_CALPER, `IDPS_OFS_CALCNT,
      `IDPS_OFS_TRNLEN, `IDPS_OFS_TRNGAP, `IDPS_OFS_TRNCNT, `IDPS_OFS_ANGREF,
      `IDPS_OFS_ANGSTART, `IDPS_OFS_ANGSTEP: mapped = 1'b1;
      default: mapped = ph_hit;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  logic sp_take;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      allow_r <= 1'b0;
      boost_on_r <= 1'b0;
      drv_en_r <= 1'b0;
      chan_on_r <= 3'h0;
      invert_r <= 3'h0;
      src_r <= IDPS_SRC_DIRECT;
      cap_r <= 1'b0;
      early_r <= 1'b0;
      trg_fall_r <= 1'b0;
      sp_tgt_r <= 2'h0;
      boost_set_r <= `IDPS_RST_BOOST;
      recov_len_r <= 16'h0000;
      sp_len_r <= 16'h0000;
      cal_len_r <= 16'h0000;
      cal_per_r <= 16'h0000;
      trn_len_r <= 16'h0000;
      trn_gap_r <= 16'h0000;
      trn_cnt_r <= 4'h0;
      ang_ref_r <= 16'h0000;
      ang_start_r <= 16'h0000;
      ang_step_r <= 16'h0000;
    end else if (wr) begin
      unique case (PADDR)
        `IDPS_OFS_CTRL: begin
          allow_r <= PWDATA[`IDPS_B_ALLOW];
          boost_on_r <= PWDATA[`IDPS_B_BOOST];
          drv_en_r <= PWDATA[`IDPS_B_DRIVE];
          chan_on_r <= PWDATA[`IDPS_B_CHON +: 3];
          invert_r <= PWDATA[`IDPS_B_INV +: 3];
          src_r <= idps_src_t'(PWDATA[`IDPS_B_SRC +: 2]);
          cap_r <= PWDATA[`IDPS_B_CAP];
          early_r <= PWDATA[`IDPS_B_EARLY];
          trg_fall_r <= PWDATA[`IDPS_B_TRGFALL];
          sp_tgt_r <= PWDATA[`IDPS_B_SPTGT +: 2];
        end
        `IDPS_OFS_BOOST: boost_set_r <= PWDATA[7:0];
        `IDPS_OFS_RECOV: recov_len_r <= PWDATA[15:0];
        `IDPS_OFS_SPLEN: sp_len_r <= PWDATA[15:0];
        `IDPS_OFS_CALLEN: cal_len_r <= PWDATA[15:0];
        `IDPS_OFS_CALPER: cal_per_r <= PWDATA[15:0];
        `IDPS_OFS_TRNLEN: trn_len_r <= PWDATA[15:0];
        `IDPS_OFS_TRNGAP: trn_gap_r <= PWDATA[15:0];
        `IDPS_OFS_TRNCNT: trn_cnt_r <= PWDATA[3:0];
        `IDPS_OFS_ANGREF: ang_ref_r <= PWDATA[15:0];
        `IDPS_OFS_ANGSTART: ang_start_r <= PWDATA[15:0];
        `IDPS_OFS_ANGSTEP: ang_step_r <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // software write wins over the self-clear so a fresh request is never lost
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) sp_req_r <= 1'b0;
    else if (wr && PADDR == `IDPS_OFS_CTRL) sp_req_r <= PWDATA[`IDPS_B_SPREQ];
    else if (sp_take) sp_req_r <= 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPH; gi++) begin : g_ph
      always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
          ph_ceil_r[gi] <= 8'h00;
          ph_floor_r[gi] <= 8'h00;
          ph_len_r[gi] <= 15'h0000;
          ph_hv_r[gi] <= 1'b0;
        end else if (wr && ph_hit && ph_ix == 3'(gi)) begin
          ph_ceil_r[gi] <= PWDATA[7:0];
          ph_floor_r[gi] <= PWDATA[`IDPS_B_FLOOR +: 8];
          ph_len_r[gi] <= PWDATA[`IDPS_B_PLEN +: 15];
          ph_hv_r[gi] <= PWDATA[`IDPS_B_HV];
        end
      end
    end
  endgenerate

  // pulse engine shared by calibration, train, angle and single pulse
  idps_pg_t pg_st_r;
  logic [15:0] pg_tmr_r, pg_left_r, pg_len_r, pg_gap_r;
  logic [2:0] pg_ch_r;
  logic [15:0] ang_tgt_r, ang_prev_r;
  logic [3:0] ang_idx_r;
  logic launch;
  logic [15:0] l_len, l_gap, l_cnt;
  logic [2:0] l_ch;
  wire one_on = (chan_on_r == 3'b001) | (chan_on_r == 3'b010) | (chan_on_r == 3'b100);
  wire trig_edge = trg_fall_r ? (trig_d_r & ~trig_s) : (~trig_d_r & trig_s);
  wire ang_wrap = CRANK_ANGLE < ang_prev_r;
  wire pg_idle = (pg_st_r == IDPS_PG_IDLE);
  wire cal_fire = pg_idle && src_r == IDPS_SRC_CAL && cal_rem_r != 16'h0000 && one_on;
  wire ang_fire = pg_idle && src_r == IDPS_SRC_ANGLE && !ang_wrap
    && ang_idx_r < trn_cnt_r && CRANK_ANGLE == ang_tgt_r;

  always_comb begin
    sp_take = 1'b0;
    launch = 1'b0;
    l_len = trn_len_r;
    l_gap = 16'h0000;
    l_cnt = 16'h0001;
    l_ch = chan_on_r;
    if (sp_req_r && sp_tgt_r == 2'h0) begin
      sp_take = 1'b1;
    end else if (sp_req_r && pg_idle) begin
      sp_take = 1'b1;
      launch = 1'b1;
      l_len = sp_len_r;
      l_ch = 3'b001 << (sp_tgt_r - 2'h1);
    end else if (cal_fire) begin
      launch = 1'b1;
      l_len = cal_len_r;
      l_gap = (cal_per_r > cal_len_r) ? cal_per_r - cal_len_r : 16'h0000;
    end else if (pg_idle && src_r == IDPS_SRC_TRAIN && trig_edge && trn_cnt_r != 4'h0) begin
      launch = 1'b1;
      l_gap = trn_gap_r;
      l_cnt = {12'h000, trn_cnt_r};
    end else if (ang_fire) begin
      launch = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) cal_rem_r <= 16'h0000;
    else if (wr && PADDR == `IDPS_OFS_CALCNT) cal_rem_r <= PWDATA[15:0];
    else if (cal_fire && !sp_req_r) cal_rem_r <= cal_rem_r - 16'h0001;
  end

  // angle targets advance by addition, avoiding a multiplier
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ang_prev_r <= 16'h0000;
      ang_tgt_r <= 16'h0000;
      ang_idx_r <= 4'h0;
    end else begin
      ang_prev_r <= CRANK_ANGLE;
      if (ang_wrap) begin
        ang_tgt_r <= ang_ref_r + ang_start_r;
        ang_idx_r <= 4'h0;
      end else if (ang_fire && !sp_req_r) begin
        ang_tgt_r <= ang_tgt_r + ang_step_r;
        ang_idx_r <= ang_idx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pg_st_r <= IDPS_PG_IDLE;
      pg_tmr_r <= 16'h0000;
      pg_left_r <= 16'h0000;
      pg_len_r <= 16'h0000;
      pg_gap_r <= 16'h0000;
      pg_ch_r <= 3'h0;
    end else begin
      unique case (pg_st_r)
        IDPS_PG_IDLE: if (launch) begin
          pg_st_r <= IDPS_PG_PULSE;
          pg_tmr_r <= l_len;
          pg_len_r <= l_len;
          pg_gap_r <= l_gap;
          pg_left_r <= l_cnt;
          pg_ch_r <= l_ch;
        end
        IDPS_PG_PULSE: if (tick) begin
          if (pg_tmr_r != 16'h0000) pg_tmr_r <= pg_tmr_r - 16'h0001;
          else if (pg_gap_r != 16'h0000) begin
            pg_st_r <= IDPS_PG_GAP;
            pg_tmr_r <= pg_gap_r;
          end else if (pg_left_r > 16'h0001) begin
            pg_tmr_r <= pg_len_r;
            pg_left_r <= pg_left_r - 16'h0001;
          end else pg_st_r <= IDPS_PG_IDLE;
        end
        IDPS_PG_GAP: if (tick) begin
          if (pg_tmr_r != 16'h0000) pg_tmr_r <= pg_tmr_r - 16'h0001;
          else if (pg_left_r > 16'h0001) begin
            pg_st_r <= IDPS_PG_PULSE;
            pg_tmr_r <= pg_len_r;
            pg_left_r <= pg_left_r - 16'h0001;
          end else pg_st_r <= IDPS_PG_IDLE;
        end
        default: pg_st_r <= IDPS_PG_IDLE;
      endcase
    end
  end

  // command gating and the 5 ms ceiling
  wire [2:0] din_act = din_s ^ invert_r;
  wire din_multi = (din_act[0] & din_act[1]) | (din_act[0] & din_act[2])
    | (din_act[1] & din_act[2]);
  wire [2:0] dir_req = (src_r == IDPS_SRC_DIRECT && !din_multi) ? din_act : 3'h0;
  wire [2:0] pg_req = (pg_st_r == IDPS_PG_PULSE) ? pg_ch_r : 3'h0;
  wire en_ok = det_r & drv_en_r;
  wire [2:0] cmd_gate = (dir_req | pg_req) & chan_on_r & {NCH{en_ok}};
  logic [22:0] age_r;
  logic cut_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      age_r <= 23'h000000;
      cut_r <= 1'b0;
    end else if (cmd_gate == 3'h0) begin
      age_r <= 23'h000000;
      cut_r <= 1'b0;
    end else if (age_r >= 23'(MAX_CMD_TICKS)) cut_r <= 1'b1;
    else if (tick) age_r <= age_r + 23'h000001;
  end
  wire [2:0] cmd_eff = cut_r ? 3'h0 : cmd_gate;
  wire cmd_on = cmd_eff != 3'h0;

  // phase sequencer
  idps_sq_t sq_st_r;
  logic [2:0] ph_r, sq_ch_r;
  logic [15:0] tmr_r;
  logic sw_on_r;
  wire [2:0] last_ph = cap_r ? 3'd3 : 3'd7;
  wire [15:0] cur_len = {1'b0, ph_len_r[ph_r]};
  wire len_done = cur_len != 16'h0000 && tmr_r + 16'h0001 >= cur_len;
  wire peak = ph_r == 3'd0 && early_r && !cap_r && SENSE_CURRENT >= ph_ceil_r[0];
  logic adv;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      sq_st_r <= IDPS_SQ_IDLE;
      ph_r <= 3'd0;
      tmr_r <= 16'h0000;
      sq_ch_r <= 3'h0;
    end else begin
      unique case (sq_st_r)
        IDPS_SQ_IDLE, IDPS_SQ_RECOV: begin
          if (cmd_on) begin
            sq_st_r <= IDPS_SQ_DRIVE;
            ph_r <= 3'd0;
            tmr_r <= 16'h0000;
            sq_ch_r <= cmd_eff;
          end else if (sq_st_r == IDPS_SQ_RECOV && tick) begin
            if (tmr_r + 16'h0001 >= recov_len_r) sq_st_r <= IDPS_SQ_IDLE;
            else tmr_r <= tmr_r + 16'h0001;
          end
        end
        IDPS_SQ_DRIVE: begin
          tmr_r <= 16'h0000;
          if (!cmd_on) begin
            if (cap_r) begin
              sq_st_r <= IDPS_SQ_DISCH;
              ph_r <= 3'd4;
            end else if (recov_len_r != 16'h0000) sq_st_r <= IDPS_SQ_RECOV;
            else sq_st_r <= IDPS_SQ_IDLE;
          end else if (peak) ph_r <= 3'd1;
          else if (tick && len_done && ph_r != last_ph) ph_r <= ph_r + 3'd1;
          else if (tick && !len_done) tmr_r <= tmr_r + 16'h0001;
          else tmr_r <= tmr_r;
        end
        IDPS_SQ_DISCH: if (tick) begin
          // zero length skips the phase, nothing left to hold for
          if (len_done || cur_len == 16'h0000) begin
            tmr_r <= 16'h0000;
            if (ph_r == 3'd7) sq_st_r <= IDPS_SQ_IDLE;
            else ph_r <= ph_r + 3'd1;
          end else tmr_r <= tmr_r + 16'h0001;
        end
      endcase
    end
  end

  // hysteretic regulation, restarting drive when a command starts from idle or recovery
  assign adv = (sq_st_r == IDPS_SQ_IDLE || sq_st_r == IDPS_SQ_RECOV) && cmd_on;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) sw_on_r <= 1'b0;
    else if (adv) sw_on_r <= 1'b1;
    else if (SENSE_CURRENT >= ph_ceil_r[ph_r]) sw_on_r <= 1'b0;
    else if (SENSE_CURRENT <= ph_floor_r[ph_r]) sw_on_r <= 1'b1;
  end

  wire drv = sq_st_r == IDPS_SQ_DRIVE && sw_on_r && cmd_on && en_ok;
  wire hv_sel = cap_r | ph_hv_r[ph_r];
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      CH_SELECT <= 3'h0;
      HV_ON <= 1'b0;
      LV_ON <= 1'b0;
      DISCHARGE_ON <= 1'b0;
      RECOVER_ON <= 1'b0;
      BOOST_EN <= 1'b0;
      BOOST_SETPOINT <= `IDPS_RST_BOOST;
      MODULE_DETECTED <= 1'b0;
    end else begin
      CH_SELECT <= (sq_st_r != IDPS_SQ_IDLE && en_ok) ? sq_ch_r : 3'h0;
      HV_ON <= drv & hv_sel;
      LV_ON <= drv & ~hv_sel;
      DISCHARGE_ON <= sq_st_r == IDPS_SQ_DISCH && sw_on_r && en_ok;
      RECOVER_ON <= sq_st_r == IDPS_SQ_RECOV && en_ok;
      BOOST_EN <= boost_on_r & det_r;
      BOOST_SETPOINT <= boost_set_r;
      MODULE_DETECTED <= det_r;
    end
  end

  // read data captured in setup so it is stable through the access phase
  logic [31:0] rd;
  always_comb begin
    rd = 32'h00000000;
    if (ph_hit) rd = {ph_hv_r[ph_ix], ph_len_r[ph_ix], ph_floor_r[ph_ix], ph_ceil_r[ph_ix]};
    else begin
      unique case (PADDR)
        `IDPS_OFS_CTRL: rd = {15'h0000, sp_tgt_r, sp_req_r, trg_fall_r, early_r, cap_r,
          src_r, invert_r, chan_on_r, drv_en_r, boost_on_r, allow_r};
        `IDPS_OFS_STATUS: rd = {21'h00000, din_multi, cut_r, sq_st_r, ph_r, CH_SELECT,
          MODULE_DETECTED};
        `IDPS_OFS_BOOST: rd = {24'h000000, boost_set_r};
        `IDPS_OFS_RECOV: rd = {16'h0000, recov_len_r};
        `IDPS_OFS_SPLEN: rd = {16'h0000, sp_len_r};
        `IDPS_OFS_CALLEN: rd = {16'h0000, cal_len_r};
        `IDPS_OFS_CALPER: rd = {16'h0000, cal_per_r};
        `IDPS_OFS_CALCNT: rd = {16'h0000, cal_rem_r};
        `IDPS_OFS_TRNLEN: rd = {16'h0000, trn_len_r};
        `IDPS_OFS_TRNGAP: rd = {16'h0000, trn_gap_r};
        `IDPS_OFS_TRNCNT: rd = {28'h0000000, trn_cnt_r};
        `IDPS_OFS_ANGREF: rd = {16'h0000, ang_ref_r};
        `IDPS_OFS_ANGSTART: rd = {16'h0000, ang_start_r};
        `IDPS_OFS_ANGSTEP: rd = {16'h0000, ang_step_r};
        default: rd = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) PRDATA <= 32'h00000000;
    else if (setup) PRDATA <= rd;
  end
endmodule // idps_top

// ===== bench/idps_props.sv
// port-level assertions for the injector drive phase sequencer
`timescale 1ns/10ps
module idps_props
  import idps_pkg::*;
#(
  parameter int MAX_CMD_TICKS = 5000
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SLOT_OCCUPIED,
  input wire logic EXT_POWER_OK,
  input wire logic MODULE_DETECTED,
  input wire logic BOOST_EN,
  input wire logic [2:0] CH_SELECT,
  input wire logic HV_ON,
  input wire logic LV_ON,
  input wire logic DISCHARGE_ON,
  input wire logic RECOVER_ON
);
  // cut happens on a tick boundary, so allow two ticks of slack
  localparam int LIM = MAX_CMD_TICKS * 250 + 500;
  int run_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N || CH_SELECT == 3'h0 || RECOVER_ON) begin
      run_r <= 0;
    end else begin
      run_r <= run_r + 1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  a_detect_needs_pins: assert property (
    MODULE_DETECTED |-> $past(SLOT_OCCUPIED & EXT_POWER_OK, 4))
    else $error("detected without slot or power");
  a_boost_needs_det: assert property (
    BOOST_EN |-> MODULE_DETECTED || $past(MODULE_DETECTED)) else $error("boost without module");
  a_drive_needs_det: assert property (
    (HV_ON || LV_ON) |-> MODULE_DETECTED || $past(MODULE_DETECTED))
    else $error("drive without module");
  a_one_channel: assert property (
    $onehot0(CH_SELECT)) else $error("more than one channel served");
  a_single_rail: assert property (
    !(HV_ON && LV_ON)) else $error("both rails on");
  a_drive_has_chan: assert property (
    (HV_ON || LV_ON || DISCHARGE_ON) |-> $onehot(CH_SELECT))
    else $error("drive with no channel");
  a_recover_quiet: assert property (
    RECOVER_ON |-> !HV_ON && !LV_ON && CH_SELECT != 3'h0) else $error("recovery while driving");
  a_recover_after: assert property (
    $rose(RECOVER_ON) |-> ($past(CH_SELECT, 1) | $past(CH_SELECT, 2)) == CH_SELECT)
    else $error("recovery not on the driven channel");
  a_disch_boost: assert property (
    DISCHARGE_ON |-> !LV_ON) else $error("battery rail in discharge");
  a_cmd_cut: assert property (
    run_r <= LIM) else $error("command not cut off");
endmodule // idps_props
bind idps_top idps_props #(.MAX_CMD_TICKS(MAX_CMD_TICKS)) u_props (
  .CLK_SYS, .RESET_N, .SLOT_OCCUPIED, .EXT_POWER_OK, .MODULE_DETECTED, .BOOST_EN,
  .CH_SELECT, .HV_ON, .LV_ON, .DISCHARGE_ON, .RECOVER_ON
);

// ===== bench/idps_load_model.sv
// injector load model: coil current follows the rail switches
`timescale 1ns/10ps
module idps_load_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hv_on,
  input wire logic lv_on,
  output logic [7:0] current
);
  // boost rail ramps faster than battery; coil decays when undriven
  always_ff @(posedge clk) begin
    if (!rst_n) current <= 8'h00;
    else if (hv_on && current < 8'hF0) current <= current + 8'h02;
    else if (lv_on && current < 8'hF0) current <= current + 8'h01;
    else if (!hv_on && !lv_on && current != 8'h00) current <= current - 8'h01;
  end
endmodule // idps_load_model

// ===== bench/testbench.sv
// self-checking bench for the injector drive phase sequencer
`timescale 1ns/10ps
`include "idps_params.svh"
module testbench;
  localparam int MAXT = 20;
  logic CLK_SYS = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic SLOT_OCCUPIED = 1'b1, EXT_POWER_OK = 1'b1, TRIGGER_IN = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [2:0] DIRECT_IN = 3'h0;
  logic [15:0] CRANK_ANGLE = 16'h0;
  logic PREADY, PSLVERR, MODULE_DETECTED, BOOST_EN, HV_ON, LV_ON, DISCHARGE_ON, RECOVER_ON;
  logic [7:0] SENSE_CURRENT, BOOST_SETPOINT;
  logic [31:0] PRDATA, rd;
  logic [2:0] CH_SELECT;
  logic err;
  int n_mismatch = 0;
  int checked = 0;
  // {allow, boost_on, slot, power, detected, boost_en}
  logic [5:0] det_rows [5] = '{6'b111111, 6'b011100, 6'b110100, 6'b111000, 6'b101110};
  logic [7:0] ra [4] = '{`IDPS_OFS_BOOST, `IDPS_OFS_RECOV, `IDPS_OFS_PHASE + 8'h10, 8'h3C};
  logic [31:0] rv [4] = '{32'h64, 32'h2, 32'h0003_1E28, 32'h55};
  logic [31:0] rx [4] = '{32'h64, 32'h2, 32'h0003_1E28, 32'h0};
  idps_top #(.MAX_CMD_TICKS(MAXT)) dut (
    .CLK_SYS, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .SLOT_OCCUPIED, .EXT_POWER_OK, .DIRECT_IN, .TRIGGER_IN, .CRANK_ANGLE,
    .SENSE_CURRENT, .MODULE_DETECTED, .BOOST_EN, .BOOST_SETPOINT, .CH_SELECT, .HV_ON,
    .LV_ON, .DISCHARGE_ON, .RECOVER_ON
  );
  idps_load_model load (.clk(CLK_SYS), .rst_n(RESET_N), .hv_on(HV_ON), .lv_on(LV_ON),
    .current(SENSE_CURRENT));
  initial forever #2 CLK_SYS = ~CLK_SYS;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run;
  endtask
  // one idle cycle after each transfer keeps strobes single-assigned
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK_SYS);
      i++;
    end while (PREADY !== 1'b1 && i < 50);
    if (PREADY !== 1'b1) timeout;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] on, inv, input logic [1:0] src, tgt);
    return 32'h7 | 32'(on) << `IDPS_B_CHON | 32'(inv) << `IDPS_B_INV
      | 32'(src) << `IDPS_B_SRC | 32'(tgt) << `IDPS_B_SPTGT;
  endfunction
  function automatic logic flag(input int k);
    logic [3:0] v;
    v = {DISCHARGE_ON, HV_ON, RECOVER_ON, LV_ON};
    return v[k];
  endfunction
  task automatic wait_flag(input int k, input int lim);
    for (int i = 0; i < lim && flag(k) !== 1'b1; i++) @(posedge CLK_SYS);
    if (flag(k) !== 1'b1) timeout;
    chk(flag(k), 1'b1);
  endtask
  task automatic wait_sel(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && CH_SELECT !== exp; i++) @(posedge CLK_SYS);
    if (CH_SELECT !== exp) timeout;
    chk(CH_SELECT, exp);
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge CLK_SYS);
      seen = seen | (CH_SELECT != 3'h0) | HV_ON | LV_ON;
    end
    chk(seen, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    chk({MODULE_DETECTED, BOOST_EN, CH_SELECT, HV_ON, LV_ON, DISCHARGE_ON, RECOVER_ON}, 0);
    chk(BOOST_SETPOINT, `IDPS_RST_BOOST);
    RESET_N <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      SLOT_OCCUPIED <= det_rows[i][3];
      EXT_POWER_OK <= det_rows[i][2];
      apb(1'b1, `IDPS_OFS_CTRL, {30'h0, det_rows[i][4], det_rows[i][5]});
      repeat (8) @(posedge CLK_SYS);
      chk(MODULE_DETECTED, det_rows[i][1]);
      chk(BOOST_EN, det_rows[i][0]);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ra[i], rv[i]);
      chk(err, i == 3);
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rx[i]);
    end
    chk(BOOST_SETPOINT, 8'h64);
    $display("table tests done");
    apb(1'b1, `IDPS_OFS_PHASE, 32'h8002_1314);
    apb(1'b1, `IDPS_OFS_PHASE + 8'h04, 32'h0000_0E0F);
    apb(1'b1, `IDPS_OFS_SPLEN, 32'h3);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd0, 2'd0));
    DIRECT_IN <= 3'b001;
    wait_sel(3'b001, 20);
    wait_flag(2, 20);
    wait_flag(0, 1000);
    repeat (1000) @(posedge CLK_SYS);
    chk(CH_SELECT, 3'b001);
    chk(HV_ON, 1'b0);
    chk(SENSE_CURRENT < 8'h06 || SENSE_CURRENT > 8'h18, 1'b0);
    DIRECT_IN <= 3'b000;
    wait_flag(1, 30);
    wait_sel(3'b000, 1000);
    DIRECT_IN <= 3'b001;
    wait_sel(3'b001, 20);
    wait_flag(1, MAXT * 250 + 600);
    DIRECT_IN <= 3'b000;
    wait_sel(3'b000, 1000);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b001, 2'd0, 2'd0));
    wait_sel(3'b001, 20);
    DIRECT_IN <= 3'b001;
    wait_sel(3'b000, 1000);
    $display("direct tests done");
    DIRECT_IN <= 3'b100;
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b011, 3'b000, 2'd0, 2'd0));
    quiet(100);
    DIRECT_IN <= 3'b011;
    quiet(100);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd0, 2'd0) & ~32'h4);
    DIRECT_IN <= 3'b001;
    quiet(100);
    DIRECT_IN <= 3'b000;
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b111, 3'b000, 2'd0, 2'd2));
    quiet(50);
    $display("gating tests done");
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b111, 3'b000, 2'd0, 2'd2) | 32'h1 << `IDPS_B_SPREQ);
    wait_sel(3'b010, 30);
    apb(1'b0, `IDPS_OFS_CTRL, 32'h0);
    chk(rd[`IDPS_B_SPREQ], 1'b0);
    wait_sel(3'b000, 3000);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b111, 3'b000, 2'd0, 2'd0) | 32'h1 << `IDPS_B_SPREQ);
    quiet(300);
    $display("single pulse tests done");
    apb(1'b1, `IDPS_OFS_CALLEN, 32'h2);
    apb(1'b1, `IDPS_OFS_CALPER, 32'hA);
    apb(1'b1, `IDPS_OFS_CALCNT, 32'h2);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b011, 3'b000, 2'd1, 2'd0));
    quiet(3000);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd1, 2'd0));
    wait_sel(3'b001, 3000);
    wait_sel(3'b000, 3000);
    wait_sel(3'b001, 3000);
    wait_sel(3'b000, 3000);
    quiet(3000);
    apb(1'b0, `IDPS_OFS_CALCNT, 32'h0);
    chk(rd, 32'h0);
    $display("calibration tests done");
    apb(1'b1, `IDPS_OFS_TRNLEN, 32'h2);
    apb(1'b1, `IDPS_OFS_TRNGAP, 32'h2);
    apb(1'b1, `IDPS_OFS_TRNCNT, 32'h1);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd2, 2'd0));
    quiet(50);
    TRIGGER_IN <= 1'b1;
    wait_sel(3'b001, 20);
    wait_sel(3'b000, 3000);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd2, 2'd0) | 32'h1 << `IDPS_B_TRGFALL);
    quiet(300);
    TRIGGER_IN <= 1'b0;
    wait_sel(3'b001, 20);
    wait_sel(3'b000, 3000);
    $display("train tests done");
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd0, 2'd0) | 32'h1 << `IDPS_B_CAP);
    DIRECT_IN <= 3'b001;
    wait_sel(3'b001, 20);
    repeat (700) @(posedge CLK_SYS);
    chk(LV_ON, 1'b0);
    DIRECT_IN <= 3'b000;
    wait_flag(3, 50);
    wait_sel(3'b000, 3000);
    $display("capacitive test done");
    CRANK_ANGLE <= 16'h0005;
    apb(1'b1, `IDPS_OFS_ANGREF, 32'h10);
    apb(1'b1, `IDPS_OFS_ANGSTART, 32'h20);
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd3, 2'd0));
    quiet(300);
    CRANK_ANGLE <= 16'h0002;
    @(posedge CLK_SYS);
    CRANK_ANGLE <= 16'h0030;
    wait_sel(3'b001, 20);
    wait_sel(3'b000, 3000);
    $display("angle test done");
    apb(1'b1, `IDPS_OFS_CTRL, ctl(3'b001, 3'b000, 2'd0, 2'd0) | 32'h1 << `IDPS_B_EARLY);
    DIRECT_IN <= 3'b001;
    wait_sel(3'b001, 20);
    wait_flag(0, 100);
    DIRECT_IN <= 3'b000;
    wait_sel(3'b000, 1000);
    $display("early advance test done");
    complete_run;
  end
endmodule // testbench
